// ==== rtl/smpp_consts.svh ====
`ifndef SMPP_CONSTS_SVH
`define SMPP_CONSTS_SVH
`define SMPP_OP_AC 8'hAC
`define SMPP_EN_SECOND 8'h53
`define SMPP_ERASE_SECOND 8'h80
`define SMPP_OP_POLL 8'hF0
`define SMPP_OP_LD_EXT 8'h4D
`define SMPP_OP_LD_HI 8'h48
`define SMPP_OP_LD_LO 8'h40
`define SMPP_OP_LD_EE 8'hC1
`define SMPP_OP_RD_HI 8'h28
`define SMPP_OP_RD_LO 8'h20
`define SMPP_OP_RD_EE 8'hA0
`define SMPP_OP_RD_LOCK 8'h58
`define SMPP_OP_RD_FUSE 8'h50
`define SMPP_OP_RD_SIG 8'h30
`define SMPP_OP_RD_CAL 8'h38
`define SMPP_OP_WR_PAGE 8'h4C
`define SMPP_OP_WR_EE 8'hC0
`define SMPP_OP_WR_EEPG 8'hC2
`define SMPP_WR_LOCK 8'hE0
`define SMPP_WR_FUSE_LO 8'hA0
`define SMPP_WR_FUSE_HI 8'hA8
`define SMPP_WR_FUSE_EXT 8'hA4
`define SMPP_SEL_HI 8'h08
`define SMPP_ERASED 8'hFF
`define SMPP_PAGE_BITS 7
`define SMPP_EEPG_BITS 2
`define SMPP_LAST_BIT 5'h1F
`define SMPP_PAGE_WRITE_WAIT_US 4500
`define SMPP_EEPROM_WRITE_WAIT_US 9000
`define SMPP_ERASE_WAIT_US 9000
`define SMPP_ENABLE_DELAY_US 20000
`define SMPP_MCLK_MHZ 125
`endif

// ==== rtl/smpp_pkg.sv ====
package smpp_pkg;
  typedef logic [31:0] smpp_frame_type;
  typedef logic [7:0] smpp_byte_type;
  typedef enum logic [1:0] {SMPP_KIND_PAGE, SMPP_KIND_EE, SMPP_KIND_ERASE} smpp_kind_type;
  typedef enum {PRG_POWER, PRG_IDLE, PRG_SHIFT, PRG_PULSE, PRG_WAIT} smpp_prg_state_type;
endpackage

// ==== rtl/smpp_if.sv ====
`timescale 1ns/1ps
interface smpp_if;
  logic sck;
  logic mosi;
  logic miso;
  logic dev_rst;
  modport dev (input sck, input mosi, input dev_rst, output miso);
  modport prg (output sck, output mosi, output dev_rst, input miso);
endinterface

// ==== rtl/smpp_dev.sv ====
`timescale 1ns/1ps
`include "smpp_consts.svh"
module smpp_dev #(
  parameter int FLASH_AW = 15,
  parameter int EE_AW = 10,
  parameter int PAGE_WAIT = `SMPP_PAGE_WRITE_WAIT_US * `SMPP_MCLK_MHZ,
  parameter int EE_WAIT = `SMPP_EEPROM_WRITE_WAIT_US * `SMPP_MCLK_MHZ,
  parameter int ERASE_WAIT = `SMPP_ERASE_WAIT_US * `SMPP_MCLK_MHZ,
  // Identity and calibration values are arbitrary
  parameter logic [7:0] SIG0 = 8'h5A,
  parameter logic [7:0] SIG1 = 8'hA5,
  parameter logic [7:0] SIG2 = 8'h3C,
  parameter logic [7:0] CALIB = 8'h80,
  parameter logic [7:0] FUSE_LO_INIT = 8'hFF,
  parameter logic [7:0] FUSE_HI_INIT = 8'hFF,
  parameter logic [7:0] FUSE_EXT_INIT = 8'hFF
)(
  input wire logic mclk,
  input wire logic reset_n,
  smpp_if.dev link,
  output logic pending_operation_flag
);
  import smpp_pkg::*;
  localparam int PW = 2 ** `SMPP_PAGE_BITS;
  localparam int EW = 2 ** `SMPP_EEPG_BITS;

  logic link_rst_n;
  logic [4:0] cnt, next_cnt;
  smpp_byte_type shin, next_shin, b1, next_b1, b2, next_b2, b3, next_b3;
  smpp_byte_type out_sh, next_out, rsp, ext_addr, next_ext;
  logic enabled, next_enabled, tgl, next_tgl, busy_s1, busy_s2, miso_q;
  smpp_kind_type kind, next_kind;
  smpp_byte_type lock, next_lock, fuse_lo, next_fuse_lo, fuse_hi, next_fuse_hi;
  smpp_byte_type fuse_ext, next_fuse_ext;
  logic we_erase, we_lo, we_hi, we_page, we_ee, we_eebuf, we_eepg;
  logic [FLASH_AW-1:0] faddr, fbase;
  logic [EE_AW-1:0] eaddr, ebase;
  smpp_byte_type flash_lo [2**FLASH_AW];
  smpp_byte_type flash_hi [2**FLASH_AW];
  smpp_byte_type ee [2**EE_AW];
  smpp_byte_type pbuf_lo [PW];
  smpp_byte_type pbuf_hi [PW];
  smpp_byte_type eebuf [EW];
  logic tgl_s1, tgl_s2, tgl_s3;
  logic [23:0] timer, next_timer;
  logic next_busy;

  // Session logic held cleared while device reset is high
  assign link_rst_n = reset_n & ~link.dev_rst;
  assign faddr = FLASH_AW'({ext_addr, b2, next_shin});
  // Page base from bytes two and three at commit time
  assign fbase = FLASH_AW'({ext_addr, b2, b3}) & ~FLASH_AW'(PW - 1);
  assign eaddr = EE_AW'({b2[1:0], next_shin});
  assign ebase = EE_AW'({b2[1:0], b3}) & ~EE_AW'(EW - 1);

  // Response byte chosen from the first three bytes
  always_comb begin
    rsp = 8'h00;
    case (b1)
      `SMPP_OP_RD_HI: rsp = flash_hi[faddr];
      `SMPP_OP_RD_LO: rsp = flash_lo[faddr];
      `SMPP_OP_RD_EE: rsp = ee[eaddr];
      `SMPP_OP_RD_LOCK: rsp = (b2 == `SMPP_SEL_HI) ? fuse_hi : lock;
      `SMPP_OP_RD_FUSE: rsp = (b2 == `SMPP_SEL_HI) ? fuse_ext : fuse_lo;
      `SMPP_OP_RD_SIG: begin
        case (next_shin[1:0])
          2'h0: rsp = SIG0;
          2'h1: rsp = SIG1;
          2'h2: rsp = SIG2;
          default: rsp = `SMPP_ERASED;
        endcase
      end
      `SMPP_OP_RD_CAL: rsp = CALIB;
      // Busy flag in the least significant bit
      `SMPP_OP_POLL: rsp = {7'h00, busy_s2};
      default: rsp = 8'h00;
    endcase
  end

  always_comb begin
    // Shift in the bit taken at the rising edge, MSB first
    next_shin = {shin[6:0], link.mosi};
    // Bit counter wraps every four bytes
    next_cnt = cnt + 5'h01;
    next_b1 = b1;
    next_b2 = b2;
    next_b3 = b3;
    next_out = {out_sh[6:0], 1'b0};
    next_enabled = enabled;
    next_ext = ext_addr;
    next_tgl = tgl;
    next_kind = kind;
    next_lock = lock;
    next_fuse_lo = fuse_lo;
    next_fuse_hi = fuse_hi;
    next_fuse_ext = fuse_ext;
    we_erase = 1'b0;
    we_lo = 1'b0;
    we_hi = 1'b0;
    we_page = 1'b0;
    we_ee = 1'b0;
    we_eebuf = 1'b0;
    we_eepg = 1'b0;
    if (cnt[2:0] == 3'h7) begin
      case (cnt[4:3])
        2'h0: next_b1 = next_shin;
        2'h1: next_b2 = next_shin;
        2'h2: next_b3 = next_shin;
        default: next_b1 = b1;
      endcase
      // Echo each byte during the next; response in byte four
      next_out = (cnt[4:3] == 2'h2) ? rsp : next_shin;
    end
    if (cnt == `SMPP_LAST_BIT) begin
      if (b1 == `SMPP_OP_AC && b2 == `SMPP_EN_SECOND) begin
        next_enabled = 1'b1;
      // Nothing is written before programming is enabled
      end else if (enabled) begin
        case (b1)
          `SMPP_OP_AC: begin
            case (b2)
              `SMPP_ERASE_SECOND: begin
                we_erase = 1'b1;
                next_lock = `SMPP_ERASED;
                next_kind = SMPP_KIND_ERASE;
                next_tgl = ~tgl;
              end
              `SMPP_WR_LOCK: next_lock = next_shin;
              `SMPP_WR_FUSE_LO: next_fuse_lo = next_shin;
              `SMPP_WR_FUSE_HI: next_fuse_hi = next_shin;
              `SMPP_WR_FUSE_EXT: next_fuse_ext = next_shin;
              default: next_lock = lock;
            endcase
            if (b2 != `SMPP_ERASE_SECOND) begin
              next_kind = SMPP_KIND_EE;
              next_tgl = ~tgl;
            end
          end
          `SMPP_OP_LD_EXT: next_ext = b3;
          `SMPP_OP_LD_LO: we_lo = 1'b1;
          `SMPP_OP_LD_HI: we_hi = 1'b1;
          `SMPP_OP_WR_PAGE: begin
            we_page = 1'b1;
            next_kind = SMPP_KIND_PAGE;
            next_tgl = ~tgl;
          end
          `SMPP_OP_WR_EE, `SMPP_OP_WR_EEPG: begin
            we_ee = (b1 == `SMPP_OP_WR_EE);
            we_eepg = (b1 == `SMPP_OP_WR_EEPG);
            next_kind = SMPP_KIND_EE;
            next_tgl = ~tgl;
          end
          `SMPP_OP_LD_EE: we_eebuf = 1'b1;
          default: next_ext = ext_addr;
        endcase
      end
    end
  end

  always_ff @(posedge link.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt <= 5'h00;
      shin <= 8'h00;
      b1 <= 8'h00;
      b2 <= 8'h00;
      b3 <= 8'h00;
      out_sh <= 8'h00;
      enabled <= 1'b0;
      ext_addr <= 8'h00;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
    end else begin
      cnt <= next_cnt;
      shin <= next_shin;
      b1 <= next_b1;
      b2 <= next_b2;
      b3 <= next_b3;
      out_sh <= next_out;
      enabled <= next_enabled;
      ext_addr <= next_ext;
      busy_s1 <= pending_operation_flag;
      busy_s2 <= busy_s1;
    end
  end

  // Nonvolatile state survives the end of a session
  always_ff @(posedge link.sck or negedge reset_n) begin
    if (!reset_n) begin
      tgl <= 1'b0;
      kind <= SMPP_KIND_PAGE;
      lock <= `SMPP_ERASED;
      fuse_lo <= FUSE_LO_INIT;
      fuse_hi <= FUSE_HI_INIT;
      fuse_ext <= FUSE_EXT_INIT;
    end else begin
      tgl <= next_tgl;
      kind <= next_kind;
      lock <= next_lock;
      fuse_lo <= next_fuse_lo;
      fuse_hi <= next_fuse_hi;
      fuse_ext <= next_fuse_ext;
    end
  end

  always_ff @(posedge link.sck) begin
    // Erase sets every location to FF
    if (we_erase) begin
      for (int i = 0; i < 2**FLASH_AW; i++) begin
        flash_lo[i] <= `SMPP_ERASED;
        flash_hi[i] <= `SMPP_ERASED;
      end
      for (int i = 0; i < 2**EE_AW; i++) begin
        ee[i] <= `SMPP_ERASED;
      end
    end
    if (we_lo) begin
      pbuf_lo[b3[`SMPP_PAGE_BITS-1:0]] <= next_shin;
    end
    if (we_hi) begin
      pbuf_hi[b3[`SMPP_PAGE_BITS-1:0]] <= next_shin;
    end
    if (we_page) begin
      for (int i = 0; i < PW; i++) begin
        flash_lo[fbase | FLASH_AW'(i)] <= pbuf_lo[i];
        flash_hi[fbase | FLASH_AW'(i)] <= pbuf_hi[i];
      end
    end
    // Byte write replaces old content, no erase needed
    if (we_ee) begin
      ee[EE_AW'({b2[1:0], b3})] <= next_shin;
    end
    if (we_eebuf) begin
      eebuf[b3[`SMPP_EEPG_BITS-1:0]] <= next_shin;
    end
    if (we_eepg) begin
      for (int i = 0; i < EW; i++) begin
        ee[ebase | EE_AW'(i)] <= eebuf[i];
      end
    end
  end

  // Output bit updated on the falling edge
  always_ff @(negedge link.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= out_sh[7];
    end
  end
  assign link.miso = miso_q;

  // Self-timed operation on the CPU clock
  always_comb begin
    next_timer = timer;
    if (tgl_s2 != tgl_s3) begin
      case (kind)
        SMPP_KIND_PAGE: next_timer = 24'(PAGE_WAIT);
        SMPP_KIND_EE: next_timer = 24'(EE_WAIT);
        SMPP_KIND_ERASE: next_timer = 24'(ERASE_WAIT);
        default: next_timer = 24'(ERASE_WAIT);
      endcase
    end else if (timer != 24'h000000) begin
      next_timer = timer - 24'h000001;
    end
    next_busy = (next_timer != 24'h000000);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      timer <= 24'h000000;
      pending_operation_flag <= 1'b0;
    end else begin
      tgl_s1 <= tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      timer <= next_timer;
      pending_operation_flag <= next_busy;
    end
  end
endmodule

// ==== rtl/smpp_prg.sv ====
`timescale 1ns/1ps
`include "smpp_consts.svh"
module smpp_prg #(
  parameter int SCK_HALF = 10,
  parameter int RST_PULSE = 4,
  parameter int ENABLE_DELAY = `SMPP_ENABLE_DELAY_US * `SMPP_MCLK_MHZ,
  parameter int PAGE_WAIT = `SMPP_PAGE_WRITE_WAIT_US * `SMPP_MCLK_MHZ,
  parameter int EE_WAIT = `SMPP_EEPROM_WRITE_WAIT_US * `SMPP_MCLK_MHZ,
  parameter int ERASE_WAIT = `SMPP_ERASE_WAIT_US * `SMPP_MCLK_MHZ
)(
  input wire logic mclk,
  input wire logic reset_n,
  smpp_if.prg link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire smpp_pkg::smpp_frame_type cmd_frame,
  output logic rsp_valid,
  output smpp_pkg::smpp_frame_type rsp_frame
);
  import smpp_pkg::*;
  smpp_prg_state_type st, next_st;
  logic [23:0] cnt, next_cnt;
  logic [4:0] bitn, next_bitn;
  smpp_frame_type tx, next_tx, rx, next_rx, cur, next_cur, next_rsp;
  logic sck, next_sck, mosi, next_mosi, rst, next_rst, retry, next_retry;
  logic next_rsp_valid, m1, m2;

  assign cmd_ready = (st == PRG_IDLE);
  assign link.sck = sck;
  assign link.mosi = mosi;
  assign link.dev_rst = rst;

  always_comb begin
    next_st = st;
    next_cnt = cnt + 24'h000001;
    next_bitn = bitn;
    next_tx = tx;
    next_rx = rx;
    next_cur = cur;
    next_rsp = rsp_frame;
    next_sck = sck;
    next_mosi = mosi;
    next_rst = rst;
    next_retry = retry;
    next_rsp_valid = 1'b0;
    case (st)
      // Reset and clock held low; then wait before enabling
      PRG_POWER: begin
        next_sck = 1'b0;
        next_rst = 1'b0;
        if (cnt >= 24'(ENABLE_DELAY - 1)) begin
          next_cnt = 24'h000000;
          next_st = retry ? PRG_SHIFT : PRG_IDLE;
          next_retry = 1'b0;
          next_tx = cur;
          next_mosi = cur[31];
          next_bitn = 5'h00;
        end
      end
      PRG_IDLE: begin
        next_cnt = 24'h000000;
        if (cmd_valid) begin
          next_cur = cmd_frame;
          next_tx = cmd_frame;
          next_mosi = cmd_frame[31];
          next_bitn = 5'h00;
          next_st = PRG_SHIFT;
        end
      end
      // Each clock phase lasts SCK_HALF cycles
      PRG_SHIFT: begin
        if (cnt >= 24'(SCK_HALF - 1)) begin
          next_cnt = 24'h000000;
          if (!sck) begin
            next_sck = 1'b1;
          end else begin
            next_sck = 1'b0;
            next_rx = {rx[30:0], m2};
            next_tx = {tx[30:0], 1'b0};
            next_mosi = tx[30];
            next_bitn = bitn + 5'h01;
            if (bitn == `SMPP_LAST_BIT) begin
              next_rsp = {rx[30:0], m2};
              next_rsp_valid = 1'b1;
              next_mosi = 1'b0;
              next_st = PRG_WAIT;
              // Fixed wait after writes and erase
              if (cur[31:24] == `SMPP_OP_WR_PAGE) begin
                next_cnt = 24'(PAGE_WAIT);
              end else if (cur[31:24] == `SMPP_OP_WR_EE || cur[31:24] == `SMPP_OP_WR_EEPG) begin
                next_cnt = 24'(EE_WAIT);
              end else if (cur[31:24] == `SMPP_OP_AC) begin
                next_cnt = (cur[23:16] == `SMPP_ERASE_SECOND) ? 24'(ERASE_WAIT) : 24'(EE_WAIT);
              end
              // Missing echo pulses reset and retries
              if (cur[31:16] == {`SMPP_OP_AC, `SMPP_EN_SECOND} &&
                  rx[14:7] != `SMPP_EN_SECOND) begin
                next_cnt = 24'h000000;
                next_st = PRG_PULSE;
              end
            end
          end
        end
      end
      PRG_PULSE: begin
        next_rst = 1'b1;
        if (cnt >= 24'(RST_PULSE)) begin
          next_rst = 1'b0;
          next_retry = 1'b1;
          next_cnt = 24'h000000;
          next_st = PRG_POWER;
        end
      end
      PRG_WAIT: begin
        next_cnt = cnt - 24'h000001;
        if (cnt <= 24'h000001) begin
          next_cnt = 24'h000000;
          next_st = PRG_IDLE;
        end
      end
      default: next_st = PRG_POWER;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= PRG_POWER;
      cnt <= 24'h000000;
      bitn <= 5'h00;
      tx <= 32'h00000000;
      rx <= 32'h00000000;
      cur <= 32'h00000000;
      rsp_frame <= 32'h00000000;
      sck <= 1'b0;
      mosi <= 1'b0;
      rst <= 1'b0;
      retry <= 1'b0;
      rsp_valid <= 1'b0;
      m1 <= 1'b0;
      m2 <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      bitn <= next_bitn;
      tx <= next_tx;
      rx <= next_rx;
      cur <= next_cur;
      rsp_frame <= next_rsp;
      sck <= next_sck;
      mosi <= next_mosi;
      rst <= next_rst;
      retry <= next_retry;
      rsp_valid <= next_rsp_valid;
      m1 <= link.miso;
      m2 <= m1;
    end
  end
endmodule

// ==== verification/smpp_link_monitor.sv ====
`timescale 1ns/1ps
module smpp_link_monitor #(
  parameter int SCK_HALF = 10
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic dev_rst
);
  logic sck_q;
  logic [4:0] bit_cnt;
  int low_run;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Rising edge count and low run length
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sck_q <= 1'b0;
      bit_cnt <= 5'h00;
      low_run <= 0;
    end else begin
      sck_q <= sck;
      if (dev_rst) begin
        bit_cnt <= 5'h00;
      end else if (sck && !sck_q) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      if (sck) begin
        low_run <= 0;
      end else if (low_run < 1000) begin
        low_run <= low_run + 1;
      end
    end
  end
  a_miso_on_fall: assert property (disable iff (!reset_n || dev_rst)
    $changed(miso) |-> $fell(sck)) else $error("miso moved off a falling serial clock");
  a_mosi_held_high: assert property (sck |-> $stable(mosi))
    else $error("mosi moved while serial clock high");
  a_sck_high_len: assert property ($rose(sck) |=> sck [*3])
    else $error("serial clock high phase too short");
  a_sck_low_len: assert property ($fell(sck) |=> !sck [*3])
    else $error("serial clock low phase too short");
  a_frame_whole: assert property (low_run == 2 * SCK_HALF + 4 |-> bit_cnt == 5'h00)
    else $error("frame gap inside a four byte frame");
  a_no_clock_rst: assert property (dev_rst |-> !$rose(sck))
    else $error("serial clock edge while device reset high");
  a_rst_pulse_len: assert property ($rose(dev_rst) |=> dev_rst)
    else $error("device reset pulse shorter than two cycles");
  a_rst_sck_low: assert property (dev_rst |-> !sck)
    else $error("serial clock not low during reset pulse");
endmodule

// ==== verification/test_serial_memory_programming_port.sv ====
`timescale 1ns/1ps
module test_serial_memory_programming_port;
  import smpp_pkg::*;
  `define CHK(nm, ex, got) begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
      num_errors++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end \
  end
  localparam smpp_byte_type SIGS [4] = '{8'h5A, 8'hA5, 8'h3C, 8'h80};
  localparam smpp_byte_type WSEL [4] = '{8'hE0, 8'hA0, 8'hA8, 8'hA4};
  localparam logic [15:0] RSEL [4] = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};
  localparam int MEM_AW = 9;
  // Device busy outlasts the programmer's fixed wait so a poll can see it
  localparam int DEV_WAIT = 1000;
  localparam int PRG_WAIT = 40;
  localparam int EN_DELAY = 50;
  localparam int HALF = 10;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  smpp_frame_type cmd_frame = '0;
  logic rsp_valid;
  smpp_frame_type rsp_frame;
  logic pend;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h2B455607;
  smpp_frame_type exp_q [$];
  smpp_frame_type msk_q [$];
  smpp_frame_type e_seen;
  smpp_frame_type m_seen;
  smpp_byte_type d [4];
  smpp_byte_type a;
  smpp_byte_type v;
  smpp_if link_bus();
  smpp_dev #(.FLASH_AW(MEM_AW), .PAGE_WAIT(DEV_WAIT), .EE_WAIT(DEV_WAIT), .ERASE_WAIT(DEV_WAIT),
    .SIG0(SIGS[0]), .SIG1(SIGS[1]), .SIG2(SIGS[2]), .CALIB(SIGS[3])) i_smpp_dev (
    .mclk(mclk),
    .reset_n(reset_n),
    .link(link_bus.dev),
    .pending_operation_flag(pend)
  );
  smpp_prg #(.SCK_HALF(HALF), .ENABLE_DELAY(EN_DELAY), .PAGE_WAIT(PRG_WAIT), .EE_WAIT(PRG_WAIT),
    .ERASE_WAIT(PRG_WAIT)) i_smpp_prg (
    .mclk(mclk),
    .reset_n(reset_n),
    .link(link_bus.prg),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready),
    .cmd_frame(cmd_frame),
    .rsp_valid(rsp_valid),
    .rsp_frame(rsp_frame)
  );
  smpp_link_monitor #(.SCK_HALF(HALF)) i_smpp_link_monitor (
    .mclk(mclk),
    .reset_n(reset_n),
    .sck(link_bus.sck),
    .mosi(link_bus.mosi),
    .miso(link_bus.miso),
    .dev_rst(link_bus.dev_rst)
  );
  always #4 mclk = ~mclk;
  function automatic smpp_byte_type rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic test_done();
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Queue the echo of bytes one and two plus the masked fourth byte
  task automatic send(input smpp_frame_type f, input smpp_byte_type r, input smpp_byte_type rm);
    while (cmd_ready !== 1'b1) begin
      @(posedge mclk);
      #1;
    end
    exp_q.push_back({8'h00, f[31:16], r & rm});
    msk_q.push_back({8'h00, 16'hFFFF, rm});
    cmd_frame = f;
    cmd_valid = 1'b1;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
  endtask
  task automatic drain();
    while (exp_q.size() != 0) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    @(posedge mclk);
    #1;
  endtask
  always @(negedge mclk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("MISMATCH rsp_frame expected none seen %h", rsp_frame);
      end else begin
        e_seen = exp_q.pop_front();
        m_seen = msk_q.pop_front();
        `CHK("rsp_frame", e_seen, rsp_frame & m_seen)
      end
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    do_reset();
    send(32'hAC530000, 8'h00, 8'h00);
    send(32'hAC800000, 8'h00, 8'h00);
    drain();
    repeat (8) @(posedge mclk);
    #1;
    `CHK("busy", 1'b1, pend)
    send(32'hF0000000, 8'h01, 8'h01);
    send(32'hF0000000, 8'h00, 8'h01);
    a = (rnd() & 8'h7C) | 8'h80;
    send({8'h20, 8'h00, a, 8'h00}, 8'hFF, 8'hFF);
    send({8'h28, 8'h00, a, 8'h00}, 8'hFF, 8'hFF);
    send(32'hA0012300, 8'hFF, 8'hFF);
    send(32'h4D000000, 8'h00, 8'h00);
    for (int k = 0; k < 4; k++) begin
      d[k] = rnd();
      send({8'h40, 8'h00, a | k[7:0], d[k]}, 8'h00, 8'h00);
      send({8'h48, 8'h00, a | k[7:0], ~d[k]}, 8'h00, 8'h00);
    end
    send({8'h4C, 8'h00, 8'h80 | (rnd() & 8'h7F), 8'h00}, 8'h00, 8'h00);
    for (int k = 0; k < 4; k++) begin
      send({8'h20, 8'h00, a | k[7:0], 8'h00}, d[k], 8'hFF);
      send({8'h28, 8'h00, a | k[7:0], 8'h00}, ~d[k], 8'hFF);
    end
    v = rnd();
    send({8'hC0, 8'h01, 8'h23, ~v}, 8'h00, 8'h00);
    send({8'hC0, 8'h01, 8'h23, v}, 8'h00, 8'h00);
    send(32'hA0012300, v, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      send({8'hC1, 8'h00, k[7:0], d[k]}, 8'h00, 8'h00);
    end
    send(32'hC2004000, 8'h00, 8'h00);
    for (int k = 0; k < 4; k++) begin
      send({8'hA0, 8'h00, 8'h40 | k[7:0], 8'h00}, d[k], 8'hFF);
      send({8'hAC, WSEL[k], 8'h00, ~d[k]}, 8'h00, 8'h00);
      send({RSEL[k], 16'h0000}, ~d[k], 8'hFF);
    end
    for (int k = 0; k < 3; k++) begin
      send({8'h30, 8'h00, k[7:0], 8'h00}, SIGS[k], 8'hFF);
    end
    send(32'h38000000, SIGS[3], 8'hFF);
    drain();
    do_reset();
    send({8'hC0, 8'h01, 8'h23, ~v}, 8'h00, 8'h00);
    send(32'hAC530000, 8'h00, 8'h00);
    send(32'hA0012300, v, 8'hFF);
    send({8'h20, 8'h00, a, 8'h00}, d[0], 8'hFF);
    drain();
    test_done();
  end
endmodule
